/* rtl/ssrap_defines.svh */
// Constants for the serial RAM access port, both ends.
// Included by the package and design files; definitions only.
`ifndef SSRAP_DEFINES_SVH
`define SSRAP_DEFINES_SVH
`define SSRAP_CMD_BITS 8
`define SSRAP_ADDR_BITS 16
`define SSRAP_BYTE_BITS 8
`define SSRAP_CLK_NS 4
`define SSRAP_MIN_BIT_NS 1000
`define SSRAP_HALF_BIT_CYC \
   ((`SSRAP_MIN_BIT_NS / 2 + `SSRAP_CLK_NS - 1) / `SSRAP_CLK_NS)
`define SSRAP_RAM_LO 16'h0000
`define SSRAP_RAM_HI 16'h0fff
`define SSRAP_IO_LO 16'h2000
`define SSRAP_IO_HI 16'h20ff
`define SSRAP_OP_READ 2'h3
`define SSRAP_OP_WRITE 2'h2
`define SSRAP_CMD_READ_QUIET 8'hc0
`define SSRAP_CMD_WRITE_QUIET 8'h80
`define SSRAP_FIFO_DEPTH 8
`endif

/* rtl/ssrap_pkg.sv */
// Types shared by both ends of the serial RAM access port.
// Needs ssrap_defines.svh on the include path.
`include "ssrap_defines.svh"
package ssrap_pkg;
   typedef logic [`SSRAP_BYTE_BITS-1:0] ssrap_byte_t;
   typedef logic [`SSRAP_ADDR_BITS-1:0] ssrap_addr_t;
   typedef enum logic [1:0] {SSRAP_PH_CMD, SSRAP_PH_ADDR, SSRAP_PH_DATA}
      ssrap_phase_t;
endpackage

/* rtl/ssrap_link_if.sv */
// Serial link between host master and device port.
// Data-out carries meaning only while its enable is high.
`timescale 1ns/1ps
interface ssrap_link_if;
   logic host_select_n;
   logic sclk;
   logic host_serial_in;
   logic host_serial_out;
   logic host_serial_out_en;
   modport device
   (
      input host_select_n,
      input sclk,
      input host_serial_in,
      output host_serial_out,
      output host_serial_out_en
   );
   modport host
   (
      output host_select_n,
      output sclk,
      output host_serial_in,
      input host_serial_out,
      input host_serial_out_en
   );
endinterface

/* rtl/ssrap_fifo.sv */
// Parameterised valid/ready FIFO.
// Single clock, synchronous active-high reset.
`timescale 1ns/1ps
module ssrap_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_r != '0);
   assign out_data_out = mem_r[rp_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_ff @(posedge ref_clk_in)
   begin
      if (push)
         mem_r[wp_r] <= in_data_in;
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* rtl/ssrap_device.sv */
// Device end: serial slave giving a host access to RAM and I/O space.
// Link pins are asynchronous to ref_clk_in and are synchronised here.
`timescale 1ns/1ps
`include "ssrap_defines.svh"
module ssrap_device
   import ssrap_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   ssrap_link_if.device link,
   output logic mem_req_out,
   output logic mem_we_out,
   output ssrap_addr_t mem_addr_out,
   output ssrap_byte_t mem_wdata_out,
   input wire logic mem_ack_in,
   input wire ssrap_byte_t mem_rdata_in,
   output ssrap_byte_t last_cmd_out,
   output ssrap_addr_t last_addr_out,
   output logic last_addr_valid_out,
   output logic port_irq_out
);
   // =====================================================
   // Pin synchronisers
   logic [1:0] sel_s_r;
   logic [1:0] clk_s_r;
   logic [1:0] din_s_r;
   logic clk_d_r;
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         sel_s_r <= 2'h3;
         clk_s_r <= 2'h0;
         din_s_r <= 2'h0;
         clk_d_r <= 1'b0;
      end
      else
      begin
         sel_s_r <= {sel_s_r[0], link.host_select_n};
         clk_s_r <= {clk_s_r[0], link.sclk};
         din_s_r <= {din_s_r[0], link.host_serial_in};
         clk_d_r <= clk_s_r[1];
      end
   end
   logic idle;
   logic rise;
   logic fall;
   assign idle = sel_s_r[1] || rst_in;
   // Edges only count while selected
   assign rise = !idle && clk_s_r[1] && !clk_d_r;
   assign fall = !idle && !clk_s_r[1] && clk_d_r;

   // =====================================================
   // Frame shifter
   ssrap_phase_t phase_r;
   logic [2:0] bit_r;
   logic [15:0] shreg_r;
   logic addr_half_r;
   ssrap_byte_t cmd_r;
   ssrap_addr_t addr_r;
   logic byte_done;
   logic [15:0] shreg_nxt;
   assign shreg_nxt = {shreg_r[14:0], din_s_r[1]};
   assign byte_done = rise && (bit_r == 3'h7);
   logic is_rd;
   logic is_wr;
   logic quiet;
   assign is_rd = cmd_r[7:6] == `SSRAP_OP_READ;
   assign is_wr = cmd_r[7:6] == `SSRAP_OP_WRITE;
   assign quiet = (cmd_r == `SSRAP_CMD_READ_QUIET) ||
                  (cmd_r == `SSRAP_CMD_WRITE_QUIET);
   // RAM or I/O window only; other addresses drop writes and read as zero
   logic addr_ok;
   assign addr_ok = (addr_r <= `SSRAP_RAM_HI) ||
                    (addr_r >= `SSRAP_IO_LO && addr_r <= `SSRAP_IO_HI);
   logic fifo_ready;
   logic rd_pend_r;
   ssrap_byte_t tx_r;
   always_ff @(posedge ref_clk_in)
   begin
      if (idle)
      begin
         phase_r <= SSRAP_PH_CMD;
         bit_r <= 3'h0;
         shreg_r <= 16'h0000;
         addr_half_r <= 1'b0;
         cmd_r <= 8'h00;
         addr_r <= 16'h0000;
      end
      else if (rise)
      begin
         shreg_r <= shreg_nxt;
         bit_r <= bit_r + 3'h1;
         if (byte_done)
         begin
            case (phase_r)
               SSRAP_PH_CMD:
                  cmd_r <= shreg_nxt[7:0];
               SSRAP_PH_ADDR:
                  addr_half_r <= 1'b1;
               default:
                  if (is_rd || is_wr)
                     addr_r <= addr_r + 16'h0001;
            endcase
            if (phase_r == SSRAP_PH_CMD)
               phase_r <= SSRAP_PH_ADDR;
            else if (phase_r == SSRAP_PH_ADDR && addr_half_r)
            begin
               phase_r <= SSRAP_PH_DATA;
               addr_r <= shreg_nxt;
            end
         end
      end
   end

   // =====================================================
   // Last command/address and interrupt
   logic frame_r;
   logic got_cmd_r;
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         last_cmd_out <= 8'h00;
         last_addr_out <= 16'h0000;
         last_addr_valid_out <= 1'b0;
         port_irq_out <= 1'b0;
         frame_r <= 1'b0;
         got_cmd_r <= 1'b0;
      end
      else
      begin
         port_irq_out <= 1'b0;
         frame_r <= !sel_s_r[1];
         if (byte_done && phase_r == SSRAP_PH_CMD)
         begin
            last_cmd_out <= shreg_nxt[7:0];
            last_addr_valid_out <= 1'b0;
            got_cmd_r <= 1'b1;
         end
         if (byte_done && phase_r == SSRAP_PH_ADDR && addr_half_r)
         begin
            last_addr_out <= shreg_nxt;
            last_addr_valid_out <= 1'b1;
         end
         // Pulse once at frame end for non-quiet commands, even for a command-only frame
         if (frame_r && sel_s_r[1])
         begin
            got_cmd_r <= 1'b0;
            // cmd_r is cleared on this same edge, so it still holds here
            port_irq_out <= got_cmd_r && !quiet;
         end
      end
   end

   // =====================================================
   // Write path through FIFO toward memory
   logic wr_valid;
   logic [23:0] wq_data;
   logic wq_valid;
   logic wq_ready;
   assign wr_valid = byte_done && phase_r == SSRAP_PH_DATA && is_wr &&
                     addr_ok;
   ssrap_fifo #(.WIDTH(24), .DEPTH(`SSRAP_FIFO_DEPTH)) u_wq
   (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_valid_in(wr_valid),
      .in_ready_out(fifo_ready),
      .in_data_in({addr_r, shreg_nxt[7:0]}),
      .out_valid_out(wq_valid),
      .out_ready_in(wq_ready),
      .out_data_out(wq_data)
   );
   // Memory port: queued writes first, then read prefetch
   logic busy_r;
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         busy_r <= 1'b0;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 16'h0000;
         mem_wdata_out <= 8'h00;
      end
      else if (busy_r)
      begin
         if (mem_ack_in)
         begin
            busy_r <= 1'b0;
            mem_req_out <= 1'b0;
         end
      end
      else if (wq_valid)
      begin
         busy_r <= 1'b1;
         mem_req_out <= 1'b1;
         mem_we_out <= 1'b1;
         mem_addr_out <= wq_data[23:8];
         mem_wdata_out <= wq_data[7:0];
      end
      else if (rd_pend_r)
      begin
         busy_r <= 1'b1;
         mem_req_out <= 1'b1;
         mem_we_out <= 1'b0;
         mem_addr_out <= addr_r;
      end
   end
   assign wq_ready = !busy_r;

   // =====================================================
   // Read path: fetch at byte start, shift on falling edges
   logic start_rd;
   assign start_rd = byte_done && is_rd &&
      ((phase_r == SSRAP_PH_ADDR && addr_half_r) ||
       phase_r == SSRAP_PH_DATA);
   logic rd_ack;
   assign rd_ack = busy_r && mem_ack_in && !mem_we_out;
   always_ff @(posedge ref_clk_in)
   begin
      if (idle)
      begin
         rd_pend_r <= 1'b0;
         tx_r <= 8'h00;
      end
      else
      begin
         if (start_rd)
            rd_pend_r <= 1'b1;
         else if (!busy_r && !wq_valid && rd_pend_r)
            rd_pend_r <= 1'b0;
         // Slow link gives memory a half bit to answer
         if (rd_ack)
            tx_r <= addr_ok ? mem_rdata_in : 8'h00;
         else if (fall && phase_r == SSRAP_PH_DATA)
            tx_r <= {tx_r[6:0], 1'b0};
      end
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (idle)
      begin
         link.host_serial_out <= 1'b0;
         link.host_serial_out_en <= 1'b0;
      end
      else
      begin
         link.host_serial_out_en <= 1'b1;
         if (fall && phase_r == SSRAP_PH_DATA && is_rd)
            link.host_serial_out <= tx_r[7];
      end
   end
   logic unused_tx;
   // FIFO cannot fill at the link's byte rate
   assign unused_tx = fifo_ready;
endmodule

/* rtl/ssrap_host.sv */
// Host end: serial master issuing one frame per request.
// Link clock is divided from ref_clk_in; the data pin from the device is synced.
`timescale 1ns/1ps
`include "ssrap_defines.svh"
module ssrap_host
   import ssrap_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   ssrap_link_if.host link,
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire ssrap_byte_t req_cmd_in,
   input wire ssrap_addr_t req_addr_in,
   input wire logic [7:0] req_len_in,
   input wire logic req_cmd_only_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire ssrap_byte_t wr_data_in,
   output logic rd_valid_out,
   output ssrap_byte_t rd_data_out,
   output logic done_out
);
   localparam int HALF = `SSRAP_HALF_BIT_CYC;
   typedef enum logic [1:0] {SSRAP_H_IDLE, SSRAP_H_SHIFT, SSRAP_H_END}
      ssrap_hstate_t;
   ssrap_hstate_t st_r;
   logic [1:0] din_s_r;
   logic [8:0] div_r;
   logic [23:0] sh_r;
   logic [4:0] bits_r;
   logic [7:0] left_r;
   logic rd_mode_r;
   logic last_hdr_r;
   ssrap_byte_t rx_r;
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         din_s_r <= 2'h0;
      else
         din_s_r <= {din_s_r[0], link.host_serial_out};
   end
   assign req_ready_out = st_r == SSRAP_H_IDLE;
   assign wr_ready_out = 1'b0;
   // =====================================================
   // Frame sequencer
   logic half_tick;
   assign half_tick = div_r == 9'(HALF - 1);
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         st_r <= SSRAP_H_IDLE;
         link.host_select_n <= 1'b1;
         link.sclk <= 1'b0;
         link.host_serial_in <= 1'b0;
         div_r <= 9'h000;
         sh_r <= 24'h000000;
         bits_r <= 5'h00;
         left_r <= 8'h00;
         rd_mode_r <= 1'b0;
         last_hdr_r <= 1'b0;
         rx_r <= 8'h00;
         rd_valid_out <= 1'b0;
         rd_data_out <= 8'h00;
         done_out <= 1'b0;
      end
      else
      begin
         rd_valid_out <= 1'b0;
         done_out <= 1'b0;
         div_r <= half_tick ? 9'h000 : div_r + 9'h001;
         case (st_r)
            SSRAP_H_IDLE:
               if (req_valid_in)
               begin
                  // Select drops before any clock edge
                  link.host_select_n <= 1'b0;
                  sh_r <= {req_cmd_in, req_addr_in};
                  bits_r <= req_cmd_only_in ? 5'd8 : 5'd24;
                  left_r <= req_cmd_only_in ? 8'h00 : req_len_in;
                  rd_mode_r <= req_cmd_in[7:6] == `SSRAP_OP_READ;
                  last_hdr_r <= 1'b1;
                  link.host_serial_in <= req_cmd_in[7];
                  div_r <= 9'h000;
                  st_r <= SSRAP_H_SHIFT;
               end
            SSRAP_H_SHIFT:
               if (half_tick)
               begin
                  link.sclk <= !link.sclk;
                  if (!link.sclk)
                  begin
                     // Device samples on this rise
                     rx_r <= {rx_r[6:0], din_s_r[1]};
                     bits_r <= bits_r - 5'h01;
                  end
                  else if (bits_r == 5'h00)
                  begin
                     if (!last_hdr_r)
                     begin
                        rd_valid_out <= rd_mode_r;
                        rd_data_out <= rx_r;
                     end
                     if (left_r == 8'h00)
                        st_r <= SSRAP_H_END;
                     else
                     begin
                        left_r <= left_r - 8'h01;
                        bits_r <= 5'd8;
                        last_hdr_r <= 1'b0;
                        sh_r <= {wr_data_in, 16'h0000};
                        link.host_serial_in <= wr_data_in[7];
                     end
                  end
                  else
                  begin
                     sh_r <= {sh_r[22:0], 1'b0};
                     link.host_serial_in <= sh_r[22];
                  end
               end
            SSRAP_H_END:
               if (half_tick)
               begin
                  link.host_select_n <= 1'b1;
                  done_out <= 1'b1;
                  st_r <= SSRAP_H_IDLE;
               end
            default:
               st_r <= SSRAP_H_IDLE;
         endcase
      end
   end
   logic unused_wv;
   assign unused_wv = wr_valid_in;
endmodule

/* dv/ssrap_link_checker.sv */
// Assertions on the serial link between the host end and the device end.
// Sits beside the link interface; every signal is sampled on ref_clk_in.
`timescale 1ns/1ps
`include "ssrap_defines.svh"
module ssrap_link_checker
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic host_select_n,
   input wire logic sclk,
   input wire logic host_serial_in,
   input wire logic host_serial_out,
   input wire logic host_serial_out_en
);
   localparam int HALF = `SSRAP_HALF_BIT_CYC;
   logic sclk_r;
   logic [15:0] hold_r;
   logic [15:0] rise_r;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // ==========================================
   // Helper counters
   always_ff @(posedge ref_clk_in)
   begin
      sclk_r <= sclk;
   end

   // Cycles since the link clock last moved, saturating
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         hold_r <= 16'hffff;
      else if (sclk != sclk_r)
         hold_r <= 16'h0001;
      else if (hold_r != 16'hffff)
         hold_r <= hold_r + 16'h0001;
   end

   // Rising link edges within the current frame
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in || host_select_n)
         rise_r <= 16'h0000;
      else if (sclk && !sclk_r)
         rise_r <= rise_r + 16'h0001;
   end

   // ==========================================
   // Link rules
   AST_CLK_IN_FRAME: assert property ($rose(sclk) |-> !host_select_n
      && !$past(host_select_n, 8))
      else $error("link clock rose outside a frame");
   AST_SEL_SETUP: assert property ($fell(host_select_n) |->
      (!sclk) [*8])
      else $error("link clock not low after select fell");
   AST_HALF_BIT: assert property ((sclk != sclk_r) |->
      hold_r >= HALF - 1)
      else $error("link clock half period too short");
   AST_SDI_STEADY: assert property ($rose(sclk) |->
      $stable(host_serial_in) ##1 $stable(host_serial_in))
      else $error("serial input moved at a rising edge");
   AST_OE_QUIET: assert property (host_select_n [*8] |->
      !host_serial_out_en)
      else $error("serial output driven while deselected");
   AST_OE_RELEASE: assert property ($rose(host_select_n) |->
      ##[1:6] !host_serial_out_en)
      else $error("serial output not released after frame end");
   AST_SDO_ON_FALL: assert property (host_serial_out_en
      && $past(host_serial_out_en) && $changed(host_serial_out)
      |-> !sclk && hold_r <= 16'h000c)
      else $error("serial output changed away from a falling edge");
   AST_FRAME_BITS: assert property ($rose(host_select_n) |->
      rise_r == 16'h0008 || (rise_r >= 16'h0020 && rise_r[2:0] == 3'h0))
      else $error("frame did not hold whole bytes");
endmodule

/* dv/serial_slave_ram_access_port_tb.sv */
// Self-checking bench: host end and device end joined by the link.
// A behavioural memory answers the device's memory requests.
`timescale 1ns/1ps
`include "ssrap_defines.svh"
module serial_slave_ram_access_port_tb
   import ssrap_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid = 1'b0;
   logic req_ready;
   ssrap_byte_t req_cmd = 8'h00;
   ssrap_addr_t req_addr = 16'h0000;
   logic [7:0] req_len = 8'h00;
   logic req_only = 1'b0;
   ssrap_byte_t wr_data = 8'h00;
   logic rd_valid;
   ssrap_byte_t rd_data;
   logic done;
   logic mem_req;
   logic mem_we;
   ssrap_addr_t mem_addr;
   ssrap_byte_t mem_wdata;
   logic mem_ack = 1'b0;
   ssrap_byte_t mem_rdata = 8'h00;
   ssrap_byte_t last_cmd;
   ssrap_addr_t last_addr;
   logic last_addr_valid;
   logic irq;
   logic [31:0] seed = 32'h00000035;
   int fails = 0;
   int check_count = 0;
   ssrap_byte_t mem [0:65535];
   ssrap_byte_t exp_rd [$];
   ssrap_byte_t exp_irq [$];

   ssrap_link_if link();

   ssrap_host u_ssrap_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .link(link), .req_valid_in(req_valid), .req_ready_out(req_ready),
      .req_cmd_in(req_cmd), .req_addr_in(req_addr), .req_len_in(req_len),
      .req_cmd_only_in(req_only), .wr_valid_in(1'b0), .wr_ready_out(),
      .wr_data_in(wr_data), .rd_valid_out(rd_valid),
      .rd_data_out(rd_data), .done_out(done));

   ssrap_device u_ssrap_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .link(link), .mem_req_out(mem_req), .mem_we_out(mem_we),
      .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
      .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata),
      .last_cmd_out(last_cmd), .last_addr_out(last_addr),
      .last_addr_valid_out(last_addr_valid), .port_irq_out(irq));

   ssrap_link_checker u_ssrap_link_checker (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .host_select_n(link.host_select_n),
      .sclk(link.sclk), .host_serial_in(link.host_serial_in),
      .host_serial_out(link.host_serial_out),
      .host_serial_out_en(link.host_serial_out_en));

   initial
   begin
      forever #2 ref_clk_in = ~ref_clk_in;
   end

   // ==========================================
   // Helpers
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic inr(input ssrap_addr_t x);
      return x <= `SSRAP_RAM_HI || (x >= `SSRAP_IO_LO && x <= `SSRAP_IO_HI);
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic chk_q(input string n, ref ssrap_byte_t q[$],
      input ssrap_byte_t g);
      ssrap_byte_t e;
      e = (q.size() > 0) ? q.pop_front() : 8'hxx;
      chk(n, {8'h00, e}, {8'h00, g});
   endtask

   // Bounded wait for m link rises, or for done when m is zero
   task automatic wait_ev(input int m);
      int t;
      logic p;
      logic use_done;
      t = 0;
      p = link.sclk;
      use_done = (m == 0);
      while (use_done ? (done !== 1'b1) : (m > 0))
      begin
         @(posedge ref_clk_in);
         if (link.sclk === 1'b1 && p === 1'b0)
            m--;
         p = link.sclk;
         if (++t > 20000)
         begin
            fails++;
            final_report();
         end
      end
   endtask

   // ==========================================
   // Memory behind the device; ack latency is random
   always @(posedge ref_clk_in)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ssrap_byte_t'(rnd());
      if (mem_req === 1'b1 && !mem_ack && rnd() & 32'h1)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem[mem_addr];
         if (mem_we)
            mem[mem_addr] = mem_wdata;
      end
   end

   // Result watcher
   always @(posedge ref_clk_in)
   begin
      if (rd_valid === 1'b1)
         chk_q("rd_data", exp_rd, rd_data);
      if (irq === 1'b1)
         chk_q("irq_cmd", exp_irq, last_cmd);
   end

   // ==========================================
   // One frame from request to memory comparison
   task automatic frame(input ssrap_byte_t cmd, input ssrap_addr_t a,
      input int n, input logic only);
      ssrap_byte_t wd [$];
      ssrap_byte_t old [$];
      ssrap_addr_t x;
      logic wr_op;
      wr_op = cmd[7:6] == `SSRAP_OP_WRITE;
      for (int k = 0; k < n; k++)
      begin
         x = a + ssrap_addr_t'(k);
         wd.push_back(ssrap_byte_t'(rnd()));
         old.push_back(mem[x]);
         if (cmd[7:6] == `SSRAP_OP_READ)
            exp_rd.push_back(inr(x) ? mem[x] : 8'h00);
      end
      if (cmd != `SSRAP_CMD_READ_QUIET && cmd != `SSRAP_CMD_WRITE_QUIET)
         exp_irq.push_back(cmd);
      @(posedge ref_clk_in);
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_addr <= a;
      req_len <= 8'(n);
      req_only <= only;
      wr_data <= (n > 0) ? wd[0] : 8'h00;
      @(posedge ref_clk_in);
      chk("req_ready", 16'h0001, {15'h0000, req_ready});
      req_valid <= 1'b0;
      // Next byte loaded mid-way through the byte before it
      for (int k = 1; k < n; k++)
      begin
         wait_ev(k == 1 ? 28 : 8);
         wr_data <= wd[k];
      end
      wait_ev(0);
      repeat (8) @(posedge ref_clk_in);
      chk("last_cmd", {8'h00, cmd}, {8'h00, last_cmd});
      chk("addr_valid", {15'h0000, !only},
         {15'h0000, last_addr_valid});
      if (!only)
         chk("last_addr", a, last_addr);
      chk("rd_left", 16'h0000, 16'(exp_rd.size()));
      chk("irq_left", 16'h0000, 16'(exp_irq.size()));
      for (int k = 0; k < n; k++)
      begin
         x = a + ssrap_addr_t'(k);
         chk("mem", {8'h00, (wr_op && inr(x)) ? wd[k] : old[k]},
            {8'h00, mem[x]});
      end
      $display("frame cmd %h addr %h len %0d finished", cmd, a, n);
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = ssrap_byte_t'(rnd());
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      chk("irq_reset", 16'h0000, {15'h0000, irq});
      frame(8'h80, 16'h0ffe, 3, 1'b0);
      frame(8'hc0, 16'h0ffe, 3, 1'b0);
      frame(8'h85, 16'h20fe, 2, 1'b0);
      frame(8'hd3, 16'h20fe, 3, 1'b0);
      frame(8'h3c, 16'h0010, 2, 1'b0);
      frame(8'h5a, 16'h0000, 0, 1'b1);
      repeat (2)
         frame(ssrap_byte_t'(rnd()) | 8'h80, ssrap_addr_t'(rnd()) & 16'h0fff,
            1 + int'(rnd() % 2), 1'b0);
      final_report();
   end
endmodule
